//--- hw/socket_clk_consts.svh
/*
 * Constants of the socket idle clock control block: register offsets,
 * field positions, reset values and divider figures.
 * Assumes inclusion by bare name from the design and the bench.
 */
`ifndef SOCKET_CLK_CONSTS_SVH
`define SOCKET_CLK_CONSTS_SVH

// register byte offsets on the plain register port
`define OFS_POWER_MGMT   8'h20
`define OFS_IRQ_STATUS   8'h24
`define OFS_IRQ_MASK     8'h28

// field positions in the power management word
`define BIT_ACCESSED     25
`define BIT_CLK_CHANGED  24
`define BIT_POLICY_EN    16
`define BIT_SLOW_SEL     0

// interrupt status and mask layout
`define IRQ_W            2
`define IRQ_ACCESS       0
`define IRQ_CLOCK        1
`define IRQ_RESET        2'h0
`define IRQ_NONE         2'h0

// idle slow mode divides the card clock by sixteen
`define DIV_W            4
`define DIV_ZERO         4'h0
`define DIV_ONE          4'h1
`define DIV_LAST         4'hF

`define WORD_ZERO        32'h0000_0000

`endif

//--- hw/socket_clk_pkg.sv
/*
 * Types shared by the socket idle clock control block.
 * Assumes the constants header is on the include path.
 */
package socket_clk_pkg;

    // clock-run states of the card clock
    typedef enum logic [1:0] {
        CLK_RUN  = 2'b00,
        CLK_STOP = 2'b01,
        CLK_SLOW = 2'b10
    } clk_state_e;

    // one request on the plain register port
    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } reg_req_s;

    // card clock controls toward the socket clock driver
    typedef struct packed {
        logic stop;
        logic slow;
        logic tick;
    } card_clk_s;

endpackage

//--- hw/socket_idle_clock_control.sv
/*
 * Socket power management register and idle clock-run control for one
 * card socket, with sticky interrupt status and mask.
 * Assumes a register master that keeps strobes one cycle long, never
 * both at once, and a card side that reports accesses and idleness
 * synchronously to sys_clk.
 */
`timescale 1ns/1ps
`include "socket_clk_consts.svh"

module socket_idle_clock_control (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     socket_reset,
    input  wire socket_clk_pkg::reg_req_s reg_req,
    output logic [31:0]                   reg_rdata,
    input  wire logic                     card_access,
    input  wire logic                     socket_idle,
    output socket_clk_pkg::card_clk_s     card_clk,
    output logic                          irq
);
    import socket_clk_pkg::*;

    // register port decode
    logic wr_pm;
    logic rd_pm;
    logic wr_status;
    logic wr_mask;

    assign wr_pm     = reg_req.wr && (reg_req.addr == `OFS_POWER_MGMT);
    assign rd_pm     = reg_req.rd && (reg_req.addr == `OFS_POWER_MGMT);
    assign wr_status = reg_req.wr && (reg_req.addr == `OFS_IRQ_STATUS);
    assign wr_mask   = reg_req.wr && (reg_req.addr == `OFS_IRQ_MASK);

    // policy bits
    logic policy_en;
    logic slow_sel;
    logic next_policy_en;
    logic next_slow_sel;

    // sticky flags
    logic accessed;
    logic clk_changed;
    logic next_accessed;
    logic next_clk_changed;

    // clock-run state
    clk_state_e          state;
    clk_state_e          next_state;
    logic [`DIV_W-1:0]   div_cnt;
    logic [`DIV_W-1:0]   next_div_cnt;
    card_clk_s           next_card_clk;
    logic                enter_idle;

    // interrupts and read data
    logic [`IRQ_W-1:0]   irq_status;
    logic [`IRQ_W-1:0]   irq_mask;
    logic [`IRQ_W-1:0]   next_irq_status;
    logic [`IRQ_W-1:0]   next_irq_mask;
    logic [`IRQ_W-1:0]   irq_events;
    logic [31:0]         next_rdata;
    logic [31:0]         pm_word;

    // policy bits: socket reset clears them too, unlike the flags
    always_comb begin
        next_policy_en = policy_en;
        next_slow_sel  = slow_sel;
        if (socket_reset) begin
            next_policy_en = 1'b0;
            next_slow_sel  = 1'b0;
        end else if (wr_pm) begin
            next_policy_en = reg_req.wdata[`BIT_POLICY_EN];
            next_slow_sel  = reg_req.wdata[`BIT_SLOW_SEL];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            policy_en <= 1'b0;
            slow_sel  <= 1'b0;
        end else begin
            policy_en <= next_policy_en;
            slow_sel  <= next_slow_sel;
        end
    end

    // clock-run state: only an enabled policy may leave the run state
    always_comb begin
        next_state = state;
        unique case (state)
            CLK_RUN: begin
                if (policy_en && socket_idle && !card_access) begin
                    next_state = slow_sel ? CLK_SLOW : CLK_STOP;
                end
            end
            CLK_STOP, CLK_SLOW: begin
                if (!policy_en || !socket_idle || card_access) begin
                    next_state = CLK_RUN;
                end
            end
            default: begin
                next_state = CLK_RUN;
            end
        endcase
    end

    assign enter_idle = (state == CLK_RUN) && (next_state != CLK_RUN);

    // divider: one card clock tick in sixteen while slowed
    always_comb begin
        next_div_cnt       = `DIV_ZERO;
        next_card_clk.stop = (next_state == CLK_STOP);
        next_card_clk.slow = (next_state == CLK_SLOW);
        next_card_clk.tick = 1'b0;
        unique case (next_state)
            CLK_RUN: begin
                next_card_clk.tick = 1'b1;
            end
            CLK_SLOW: begin
                next_div_cnt       = div_cnt + `DIV_ONE;
                next_card_clk.tick = (next_div_cnt == `DIV_LAST);
            end
            CLK_STOP: begin
                next_card_clk.tick = 1'b0;
            end
            default: begin
                next_card_clk.tick = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state    <= CLK_RUN;
            div_cnt  <= `DIV_ZERO;
            card_clk <= '{stop: 1'b0, slow: 1'b0, tick: 1'b1};
        end else begin
            state    <= next_state;
            div_cnt  <= next_div_cnt;
            card_clk <= next_card_clk;
        end
    end

    // sticky flags; a new access beats the clearing read
    always_comb begin
        next_accessed    = card_access || (accessed && !rd_pm);
        next_clk_changed = clk_changed || enter_idle;
    end

    // flags ignore socket_reset on purpose: context survives it
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            accessed    <= 1'b0;
            clk_changed <= 1'b0;
        end else begin
            accessed    <= next_accessed;
            clk_changed <= next_clk_changed;
        end
    end

    // interrupt status: write one to clear, a same-cycle event wins
    assign irq_events = {enter_idle, card_access};

    always_comb begin
        next_irq_status = irq_status;
        next_irq_mask   = irq_mask;
        if (wr_status) begin
            next_irq_status = irq_status & ~reg_req.wdata[`IRQ_W-1:0];
        end
        next_irq_status = next_irq_status | irq_events;
        if (wr_mask) begin
            next_irq_mask = reg_req.wdata[`IRQ_W-1:0];
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            irq_status <= `IRQ_RESET;
            irq_mask   <= `IRQ_RESET;
        end else begin
            irq_status <= next_irq_status;
            irq_mask   <= next_irq_mask;
        end
    end

    assign irq = ((irq_status & irq_mask) != `IRQ_NONE);

    // read word; reserved positions are never filled
    always_comb begin
        pm_word                   = `WORD_ZERO;
        pm_word[`BIT_ACCESSED]    = accessed;
        pm_word[`BIT_CLK_CHANGED] = clk_changed;
        pm_word[`BIT_POLICY_EN]   = policy_en;
        pm_word[`BIT_SLOW_SEL]    = slow_sel;
    end

    // read data stands one cycle only; unmapped addresses read zero
    always_comb begin
        next_rdata = `WORD_ZERO;
        if (reg_req.rd) begin
            unique case (reg_req.addr)
                `OFS_POWER_MGMT: next_rdata = pm_word;
                `OFS_IRQ_STATUS: next_rdata[`IRQ_W-1:0] = irq_status;
                `OFS_IRQ_MASK:   next_rdata[`IRQ_W-1:0] = irq_mask;
                default:         next_rdata = `WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `WORD_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // checks on the design's own behaviour
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    sequence s_pm_read;
        rd_pm;
    endsequence

    sequence s_idle_enter_stop;
        state == CLK_RUN && policy_en && !slow_sel && socket_idle &&
            !card_access;
    endsequence

    sequence s_idle_enter_slow;
        state == CLK_RUN && policy_en && slow_sel && socket_idle &&
            !card_access;
    endsequence

    sequence s_slow_tick;
        state == CLK_SLOW && card_clk.tick;
    endsequence

    chk_rsvd_zero: assert property (
        s_pm_read |=> reg_rdata[31:26] == 6'h0 &&
            reg_rdata[23:17] == 7'h0 && reg_rdata[15:1] == 15'h0
    ) else $error("reserved power management bits not zero");

    chk_access_set: assert property (
        card_access |=> accessed ##1 (reg_rdata[`BIT_ACCESSED] ||
            !$past(rd_pm))
    ) else $error("access flag not set after card access");

    chk_read_clears: assert property (
        s_pm_read ##0 !card_access |=> !accessed &&
            reg_rdata[`BIT_ACCESSED] == $past(accessed)
    ) else $error("read did not return and clear access flag");

    chk_mode_stop: assert property (
        s_idle_enter_stop |=> card_clk.stop && !card_clk.tick &&
            clk_changed
    ) else $error("idle stop policy did not stop card clock");

    chk_mode_slow: assert property (
        s_idle_enter_slow |=> card_clk.slow && clk_changed
    ) else $error("idle slow policy did not slow card clock");

    chk_slow_ratio: assert property (
        s_slow_tick |=> (!card_clk.tick || state != CLK_SLOW)[*8]
    ) else $error("slowed card clock ticks too often");

    chk_slow_period: assert property (
        s_slow_tick ##1 (state == CLK_SLOW)[*8] |->
            ##[1:8] (card_clk.tick || state != CLK_SLOW)
    ) else $error("slowed card clock missed its tick");

    chk_mode_sticky: assert property (
        clk_changed |=> clk_changed
    ) else $error("clock mode flag dropped without global reset");

    chk_flags_hold: assert property (
        socket_reset && accessed && !rd_pm |=> accessed && !policy_en
    ) else $error("socket reset disturbed access flag");

    chk_disabled_run: assert property (
        !policy_en && state == CLK_RUN |=> state == CLK_RUN &&
            card_clk.tick
    ) else $error("clock left run state while control disabled");

    chk_reset_off: assert property (
        @(posedge sys_clk) disable iff (1'b0)
        rst |=> !policy_en && !accessed && !clk_changed &&
            state == CLK_RUN
    ) else $error("reset left idle control or flags set");

    // an unmasked event must raise the line even against a clearing write
    chk_irq_level: assert property (
        card_access && irq_mask[`IRQ_ACCESS] && !wr_mask |=>
            irq && irq_status[`IRQ_ACCESS]
    ) else $error("unmasked access event did not raise interrupt");

    chk_irq_clock: assert property (
        enter_idle |=> irq_status[`IRQ_CLOCK] && clk_changed
    ) else $error("clock change did not set status and mode flag");

    chk_irq_clear: assert property (
        wr_status && reg_req.wdata[`IRQ_ACCESS] && !card_access |=>
            !irq_status[`IRQ_ACCESS]
    ) else $error("write one did not clear access status");

    chk_access_wins: assert property (
        s_pm_read ##0 card_access |=> accessed
    ) else $error("clearing read beat a same-cycle card access");

    chk_policy_write: assert property (
        wr_pm && !socket_reset |=>
            policy_en == $past(reg_req.wdata[`BIT_POLICY_EN]) &&
            slow_sel == $past(reg_req.wdata[`BIT_SLOW_SEL])
    ) else $error("policy write did not land");

    chk_socket_clear: assert property (
        socket_reset |=> !policy_en && !slow_sel
    ) else $error("socket reset left idle control enabled");

    // leaving idle must give the card its full clock at once
    chk_idle_exit: assert property (
        state != CLK_RUN && (!socket_idle || card_access) |=>
            state == CLK_RUN && card_clk.tick
    ) else $error("card clock not restored on leaving idle");

    chk_rdata_idle: assert property (
        !reg_req.rd |=> reg_rdata == `WORD_ZERO
    ) else $error("read data not zero outside a read answer");

endmodule // socket_idle_clock_control

//--- dv/card_model.sv
/*
 * Behavioural plug-in card on the socket side: drives card accesses and
 * socket idleness, and counts card clock enables.
 * Assumes the bench calls its tasks from a single sequence.
 */
`timescale 1ns/1ps

module card_model (
    input  wire logic                      sys_clk,
    input  wire socket_clk_pkg::card_clk_s card_clk,
    output logic                           card_access,
    output logic                           socket_idle
);
    import socket_clk_pkg::*;

    int tick_count = 0;

    // quiet card at time zero
    initial begin
        card_access = 1'b0;
        socket_idle = 1'b0;
    end

    // counts enables so the bench can measure the slowed rate
    always @(posedge sys_clk) begin
        if (card_clk.tick === 1'b1) begin
            tick_count <= tick_count + 1;
        end
    end

    // one-cycle access, as a card cycle would show it
    task automatic touch();
        @(posedge sys_clk) card_access <= 1'b1;
        @(posedge sys_clk) card_access <= 1'b0;
    endtask

    task automatic idle(input logic v);
        @(posedge sys_clk) socket_idle <= v;
    endtask
endmodule // card_model

//--- dv/tb.sv
/*
 * Self-checking bench for the socket idle clock control block: register
 * tasks on the plain port, card model on the socket side.
 * Assumes the design's constants header is on the include path.
 */
`timescale 1ns/1ps
`include "socket_clk_consts.svh"

module tb;
    import socket_clk_pkg::*;

    logic        sys_clk;
    logic        rst;
    logic        socket_reset;
    reg_req_s    reg_req;
    logic [31:0] reg_rdata;
    logic        card_access;
    logic        socket_idle;
    card_clk_s   card_clk;
    logic        irq;
    int          mismatches = 0;
    int          checked = 0;
    int          cycles = 0;
    int          n;

    socket_idle_clock_control u_dut (
        .sys_clk(sys_clk), .rst(rst), .socket_reset(socket_reset),
        .reg_req(reg_req), .reg_rdata(reg_rdata),
        .card_access(card_access), .socket_idle(socket_idle),
        .card_clk(card_clk), .irq(irq)
    );

    card_model u_card (
        .sys_clk(sys_clk), .card_clk(card_clk),
        .card_access(card_access), .socket_idle(socket_idle)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // the whole run needs about 120 cycles; a hang stops here
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (mismatches == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic exp);
        cmp_word({31'h0, got}, {31'h0, exp});
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        reg_req.addr  <= a;
        reg_req.wdata <= d;
        reg_req.wr    <= 1'b1;
        @(posedge sys_clk);
        reg_req.wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge sys_clk);
        reg_req.addr <= a;
        reg_req.rd   <= 1'b1;
        @(posedge sys_clk);
        reg_req.rd <= 1'b0;
        #1 cmp_word(reg_rdata, exp);
    endtask

    task automatic pulse_socket_reset();
        @(posedge sys_clk) socket_reset <= 1'b1;
        @(posedge sys_clk) socket_reset <= 1'b0;
    endtask

    initial begin
        rst = 1'b1;
        socket_reset = 1'b0;
        reg_req = '0;
        repeat (10) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`OFS_POWER_MGMT, 32'h0000_0000);
        rd_chk(`OFS_IRQ_STATUS, 32'h0000_0000);
        wr(`OFS_POWER_MGMT, 32'hFFFF_FFFF);
        rd_chk(`OFS_POWER_MGMT, 32'h0001_0001);
        wr(`OFS_POWER_MGMT, 32'h0000_0000);
        rd_chk(8'h30, 32'h0000_0000);
        // access event: sticky, masked interrupt stays low
        u_card.touch();
        #1 cmp_bit(irq, 1'b0);
        rd_chk(`OFS_POWER_MGMT, 32'h0200_0000);
        rd_chk(`OFS_POWER_MGMT, 32'h0000_0000);
        // a card access in the clearing read's cycle wins
        fork
            u_card.touch();
            rd_chk(`OFS_POWER_MGMT, 32'h0000_0000);
        join
        rd_chk(`OFS_POWER_MGMT, 32'h0200_0000);
        rd_chk(`OFS_IRQ_STATUS, 32'h0000_0001);
        wr(`OFS_IRQ_MASK, 32'h0000_0003);
        #1 cmp_bit(irq, 1'b1);
        wr(`OFS_IRQ_STATUS, 32'h0000_0001);
        #1 cmp_bit(irq, 1'b0);
        // idle while disabled must leave the clock running
        u_card.idle(1'b1);
        repeat (4) @(posedge sys_clk);
        #1 cmp_bit(card_clk.stop, 1'b0);
        wr(`OFS_POWER_MGMT, 32'h0001_0000);
        repeat (2) @(posedge sys_clk);
        #1 cmp_bit(card_clk.stop, 1'b1);
        cmp_bit(irq, 1'b1);
        n = u_card.tick_count;
        repeat (16) @(posedge sys_clk);
        #1 cmp_word(32'(u_card.tick_count - n), 32'h0000_0000);
        rd_chk(`OFS_POWER_MGMT, 32'h0101_0000);
        rd_chk(`OFS_IRQ_STATUS, 32'h0000_0002);
        // slow mode: leave idle first so the state returns to run
        u_card.idle(1'b0);
        wr(`OFS_POWER_MGMT, 32'h0001_0001);
        u_card.idle(1'b1);
        repeat (2) @(posedge sys_clk);
        #1 cmp_bit(card_clk.slow, 1'b1);
        n = u_card.tick_count;
        repeat (32) @(posedge sys_clk);
        #1 cmp_word(32'(u_card.tick_count - n), 32'h0000_0002);
        // socket reset clears policy but never the flags
        u_card.idle(1'b0);
        u_card.touch();
        pulse_socket_reset();
        rd_chk(`OFS_POWER_MGMT, 32'h0300_0000);
        @(posedge sys_clk) rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rd_chk(`OFS_POWER_MGMT, 32'h0000_0000);
        #1 cmp_bit(irq, 1'b0);
        end_of_test();
    end
endmodule // tb
